// *** core/asr_pkg.sv ***
package asr_pkg;
  // Data-plane address of the status register
  localparam logic [7:0] ALU_STATUS_ADDR = 8'h03;
  // Field positions
  localparam int LOW_VOLTAGE_FLAG_BIT = 7;
  localparam int SPARE_BIT_ZERO_BIT = 6;
  localparam int RAM_BANK_SELECT_BIT = 5;
  localparam int WATCHDOG_EXPIRED_FLAG_BIT = 4;
  localparam int SLEEP_ENTERED_FLAG_BIT = 3;
  localparam int ZERO_FLAG_BIT = 2;
  localparam int NIBBLE_CARRY_FLAG_BIT = 1;
  localparam int CARRY_FLAG_BIT = 0;
  // Reset value and writable bits
  localparam logic [7:0] ALU_STATUS_RESET = 8'h00;
  localparam logic [7:0] ALU_STATUS_WR_MASK = 8'h67;
  // Arithmetic flags owned by the ALU when it updates them
  localparam logic [7:0] ALU_FLAG_MASK = 8'h07;
  // Threshold select codes from the configuration word field
  localparam logic [1:0] LVD_SEL_LOW = 2'h0;
endpackage

// *** core/asr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Level in and out
  input wire logic d_in,
  output logic d_out
);
  logic meta_reg;
  logic sync_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end
  assign d_out = sync_reg;
endmodule
`default_nettype wire

// *** core/asr_status.sv ***
// What this block does
// - Register writable by any instruction destination
// - ALU flag results override written flag bits
// - Bit 5 selects SRAM bank
// - Bit 7 reflects low-voltage comparator state only with supply reset enabled and filter off
// - Config field selects low-voltage threshold
// - Watchdog flag: set on timeout, cleared
// - Sleep flag: set on sleep, cleared
// - Zero flag tracks zero result
// - Bit 1 is nibble carry, inverted borrow
// - Bit 0 is carry, inverted borrow
`timescale 1ns/1ps
`default_nettype none
module asr_status (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Data-plane access from the core
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // ALU flag update
  input wire logic alu_flag_upd,
  input wire logic alu_zero,
  input wire logic alu_nibble_carry,
  input wire logic alu_carry,
  // Chip events
  input wire logic watchdog_timeout,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic supply_reset,
  // Low-voltage detect
  input wire logic [1:0] config_word_lvd_sel,
  input wire logic supply_reset_enable,
  input wire logic supply_filter_enable,
  input wire logic lvd_below_low,
  input wire logic lvd_below_high,
  // Status outputs
  output logic ram_bank_select,
  output logic [7:0] alu_status
);
  ////////////////////////////////////////////////////////////////////////
  logic below_low_s;
  logic below_high_s;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic bank_reg;
  logic lvd_now;

  // Comparator outputs are asynchronous to the core clock
  asr_sync u_sync_low (
    .clock(clock),
    .rst_b(rst_b),
    .d_in(lvd_below_low),
    .d_out(below_low_s)
  );
  asr_sync u_sync_high (
    .clock(clock),
    .rst_b(rst_b),
    .d_in(lvd_below_high),
    .d_out(below_high_s)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_next = status_reg;
    if (config_word_lvd_sel == asr_pkg::LVD_SEL_LOW) begin
      lvd_now = below_low_s;
    end else begin
      lvd_now = below_high_s;
    end
    if (wr_en && addr == asr_pkg::ALU_STATUS_ADDR) begin
      status_next = (status_reg & ~asr_pkg::ALU_STATUS_WR_MASK) |
                    (wr_data & asr_pkg::ALU_STATUS_WR_MASK);
    end
    if (alu_flag_upd) begin
      status_next[asr_pkg::ZERO_FLAG_BIT] = alu_zero;
      status_next[asr_pkg::NIBBLE_CARRY_FLAG_BIT] = alu_nibble_carry;
      status_next[asr_pkg::CARRY_FLAG_BIT] = alu_carry;
    end
    // Watchdog flag, timeout wins over clear
    if (watchdog_clear_instr || sleep_instr || supply_reset) begin
      status_next[asr_pkg::WATCHDOG_EXPIRED_FLAG_BIT] = 1'b0;
    end
    if (watchdog_timeout) begin
      status_next[asr_pkg::WATCHDOG_EXPIRED_FLAG_BIT] = 1'b1;
    end
    // Sleep flag, sleep wins over clear
    if (watchdog_clear_instr || supply_reset) begin
      status_next[asr_pkg::SLEEP_ENTERED_FLAG_BIT] = 1'b0;
    end
    if (sleep_instr) begin
      status_next[asr_pkg::SLEEP_ENTERED_FLAG_BIT] = 1'b1;
    end
    status_next[asr_pkg::LOW_VOLTAGE_FLAG_BIT] =
      lvd_now && supply_reset_enable && !supply_filter_enable;
    // Bank bit unused on write from ALU path
    status_next[asr_pkg::RAM_BANK_SELECT_BIT] =
      status_next[asr_pkg::RAM_BANK_SELECT_BIT];
    if (supply_reset) begin
      status_next[asr_pkg::SPARE_BIT_ZERO_BIT] = 1'b0;
      status_next[asr_pkg::RAM_BANK_SELECT_BIT] = 1'b0;
      status_next[asr_pkg::ZERO_FLAG_BIT] = 1'b0;
      status_next[asr_pkg::NIBBLE_CARRY_FLAG_BIT] = 1'b0;
      status_next[asr_pkg::CARRY_FLAG_BIT] = 1'b0;
    end
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    if (rd_en && addr == asr_pkg::ALU_STATUS_ADDR) begin
      rd_data_next = status_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= asr_pkg::ALU_STATUS_RESET;
      rd_data_reg <= asr_pkg::ALU_STATUS_RESET;
      bank_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      rd_data_reg <= rd_data_next;
      bank_reg <= status_next[asr_pkg::RAM_BANK_SELECT_BIT];
    end
  end

  assign rd_data = rd_data_reg;
  assign ram_bank_select = bank_reg;
  assign alu_status = status_reg;
endmodule
`default_nettype wire

// *** tb/asr_status_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_status_asserts (
  input wire logic clock, rst_b, wr_en, rd_en, alu_flag_upd, alu_zero,
  input wire logic alu_nibble_carry, alu_carry, watchdog_timeout,
  input wire logic watchdog_clear_instr, sleep_instr, supply_reset,
  input wire logic supply_filter_enable,
  input wire logic [7:0] addr, wr_data, rd_data, alu_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire hit = addr == asr_pkg::ALU_STATUS_ADDR;
  wire quiet = !(alu_flag_upd | watchdog_timeout | watchdog_clear_instr |
    sleep_instr | supply_reset);
  property p_wr; wr_en && hit && quiet |=>
    ((alu_status ^ $past(wr_data)) & 8'h67) == 8'h00; endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_alu; alu_flag_upd && !supply_reset |=> alu_status[2:0] ==
    $past({alu_zero, alu_nibble_carry, alu_carry}); endproperty
  a_alu: assert property (p_alu) else $error("flags");
  property p_hold; quiet |=> $stable(alu_status[4:3]); endproperty
  a_hold: assert property (p_hold) else $error("ro bits");
  property p_to; watchdog_timeout |=> alu_status[4]; endproperty
  a_to: assert property (p_to) else $error("timeout");
  property p_slp; sleep_instr && !watchdog_timeout |=>
    alu_status[4:3] == 2'b01; endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_clr; watchdog_clear_instr && !sleep_instr && !watchdog_timeout
    |=> alu_status[4:3] == 2'b00; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_flt; supply_filter_enable [*4] |-> !alu_status[7]; endproperty
  a_flt: assert property (p_flt) else $error("filter");
  property p_rd; rd_en && hit |=> rd_data == $past(alu_status); endproperty
  a_rd: assert property (p_rd) else $error("read");
endmodule
bind asr_status asr_status_asserts asr_status_asserts_inst (.*);
`default_nettype wire

// *** tb/asr_status_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_status_bench;
  logic clock = 0, rst_b = 0, wr_en = 0, rd_en = 0, alu_flag_upd = 0;
  logic alu_zero = 0, alu_nibble_carry = 0, alu_carry = 0, sleep_instr = 0;
  logic watchdog_timeout = 0, watchdog_clear_instr = 0, supply_reset = 0;
  logic supply_reset_enable = 0, supply_filter_enable = 0, lvd_below_low = 0;
  logic lvd_below_high = 0, ram_bank_select;
  logic [1:0] config_word_lvd_sel = 2'h0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, alu_status;
  int fails = 0, samples_checked = 0;
  asr_status asr_status_inst (.*);
  initial forever #5 clock = ~clock;
  task automatic cyc(int n); repeat (n) @(posedge clock); #1; endtask
  task automatic cmp(logic [7:0] g, e); samples_checked++;
    if (g !== e) begin fails++; $display("[ERR] %0t %h/%h", $time, g, e); end
  endtask
  task automatic wr(logic [7:0] a, d); addr = a; wr_data = d; wr_en = 1;
    cyc(1); wr_en = 0; endtask
  task automatic chk(logic [7:0] e); addr = 8'h03; rd_en = 1; cyc(1);
    rd_en = 0; cmp(rd_data, e); endtask
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Run needs about 70 cycles
  initial begin #20000; fails++; print_verdict; end
  initial begin
    cyc(20); rst_b = 1; cyc(1); chk(8'h00);
    // Masked byte writes, ALU flag updates, sleep and watchdog-clear instructions, watchdog timeout, supply reset and low-voltage detect alter the register
    wr(8'h03, 8'hff);
    chk(8'h67);
    cmp(alu_status, 8'h67);
    cmp({7'h00, ram_bank_select}, 8'h01);
    wr(8'h04, 8'h00); chk(8'h67);
    alu_flag_upd = 1; alu_zero = 1; alu_nibble_carry = 1; wr(8'h03, 8'h01);
    alu_flag_upd = 0; chk(8'h06);
    watchdog_timeout = 1; cyc(1); watchdog_timeout = 0; chk(8'h16);
    sleep_instr = 1; cyc(1); sleep_instr = 0; chk(8'h0e);
    watchdog_clear_instr = 1; cyc(1);
    watchdog_clear_instr = 0; chk(8'h06);
    watchdog_timeout = 1; cyc(1); watchdog_timeout = 0;
    supply_reset = 1; cyc(1); supply_reset = 0; chk(8'h00);
    supply_reset_enable = 1; lvd_below_high = 1; config_word_lvd_sel = 2'h1;
    cyc(5); chk(8'h80);
    config_word_lvd_sel = 2'h0; cyc(5); chk(8'h00);
    lvd_below_low = 1; cyc(5); chk(8'h80);
    supply_filter_enable = 1; cyc(5); chk(8'h00);
    // Filter stays on so the synchronised comparator cannot raise bit 7
    lvd_below_low = 0;
    alu_flag_upd = 1;
    alu_zero = 0;
    alu_nibble_carry = 0;
    alu_carry = 1;
    cyc(1);
    alu_flag_upd = 0;
    chk(8'h01);
    cmp(alu_status, 8'h01);
    // Reset in mid-run clears every flag
    wr(8'h03, 8'h60);
    rst_b = 0;
    cyc(2);
    rst_b = 1;
    cyc(1);
    cmp(alu_status, 8'h00);
    cmp({7'h00, ram_bank_select}, 8'h00);
    chk(8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
